// file: hw/css_stage_sequencer.sv
module css_stage_sequencer (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [15:0] mod_sample,
    output logic sample_strobe,
    input wire css_pkg::css_reg_req_s reg_req,
    output logic [15:0] reg_rdata,
    output logic [3:0] active_stage,
    output css_pkg::css_stage_cfg_s active_cfg,
    output logic result_valid,
    output logic [css_pkg::NUM_STAGES-1:0] button_pos_active,
    output logic [css_pkg::NUM_STAGES-1:0] button_neg_active
);
    localparam int NS = css_pkg::NUM_STAGES;

    logic [css_pkg::SAMPLE_DIV_W-1:0] div_q;
    logic sample_en;
    logic [15:0] control_q;
    logic [1:0] decim_q;
    logic [3:0] last_q;
    logic [3:0] stage_q;
    logic [3:0] stage_d;
    logic running_q;
    logic fresh_q;
    logic avg_done;
    logic [15:0] avg_result;
    logic [NS-1:0][15:0] result_q;
    logic [NS-1:0][13:0] route_lo_q;
    logic [NS-1:0][13:0] route_hi_q;
    logic [NS-1:0][13:0] offset_q;
    logic [3:0] wr_last;
    logic [3:0] req_last;
    logic seq_end;
    logic full_power;
    logic [9:0] addr;
    logic [9:0] stage_rel;
    logic [3:0] addr_stage;
    logic [2:0] addr_sub;
    logic in_stage_space;
    logic in_result_space;
    logic [9:0] result_rel;
    logic [15:0] rd_mux;
    logic is_diff;
    logic hi_side;
    logic lo_side;

    function automatic css_pkg::css_stage_cfg_s build_cfg(
        input logic [13:0] lo,
        input logic [13:0] hi,
        input logic [13:0] off
    );
        css_pkg::css_stage_cfg_s c;
        c.routing = {hi[11:0], lo};
        c.se_setup = hi[css_pkg::SE_SETUP_LSB +: 2];
        c.pos_offset = off[css_pkg::POS_OFFSET_LSB +: css_pkg::OFFSET_W];
        c.neg_offset = off[css_pkg::NEG_OFFSET_LSB +: css_pkg::OFFSET_W];
        return c;
    endfunction

    // fixed-rate sample enable from the system clock
    assign sample_en = (div_q == css_pkg::SAMPLE_DIV_W'(css_pkg::SAMPLE_DIV
                                                       - 1));
    assign sample_strobe = sample_en;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= '0;
        end else if (sample_en) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    css_averager u_avg (
        .clk(clk),
        .reset_n(reset_n),
        .sample_en(sample_en && running_q),
        .sample(mod_sample),
        .decim(decim_q),
        .done(avg_done),
        .result(avg_result)
    );

    // register port decode
    assign addr = reg_req.addr;
    assign stage_rel = addr - css_pkg::ADDR_STAGE_BASE;
    assign addr_stage = stage_rel[css_pkg::STAGE_STRIDE_LOG2 +: 4];
    assign addr_sub = stage_rel[2:0];
    assign in_stage_space = (addr >= css_pkg::ADDR_STAGE_BASE)
                            && (addr_stage < 4'(NS))
                            && (stage_rel[9:7] == 3'h0);
    assign result_rel = addr - css_pkg::ADDR_RESULT_FIRST;
    assign in_result_space = (addr >= css_pkg::ADDR_RESULT_FIRST)
                             && (result_rel < 10'(NS));

    always_comb begin
        rd_mux = 16'h0000;
        if (addr == css_pkg::ADDR_CONTROL) begin
            rd_mux = control_q;
        end else if (in_result_space) begin
            rd_mux = result_q[result_rel[3:0]];
        end else if (in_stage_space) begin
            case (addr_sub)
                css_pkg::SUB_ROUTE_LO: rd_mux = {2'h0, route_lo_q[addr_stage]};
                css_pkg::SUB_ROUTE_HI: rd_mux = {2'h0, route_hi_q[addr_stage]};
                css_pkg::SUB_OFFSET: rd_mux = {2'h0, offset_q[addr_stage]};
                default: rd_mux = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= rd_mux;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            control_q <= css_pkg::CONTROL_RESET;
        end else if (reg_req.we && addr == css_pkg::ADDR_CONTROL) begin
            control_q <= reg_req.wdata & css_pkg::CONTROL_MASK;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NS; g++) begin : g_stage_regs
            logic hit;
            assign hit = reg_req.we && in_stage_space && addr_stage == 4'(g);
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    route_lo_q[g] <= 14'h0000;
                    route_hi_q[g] <= 14'h0000;
                    offset_q[g] <= 14'h0000;
                end else if (hit) begin
                    if (addr_sub == css_pkg::SUB_ROUTE_LO) begin
                        route_lo_q[g] <= reg_req.wdata[13:0];
                    end
                    if (addr_sub == css_pkg::SUB_ROUTE_HI) begin
                        route_hi_q[g] <= reg_req.wdata[13:0];
                    end
                    if (addr_sub == css_pkg::SUB_OFFSET) begin
                        // six-bit codes each, upper bits held at zero
                        offset_q[g] <= reg_req.wdata[13:0]
                                       & 14'h3F3F;
                    end
                end
            end
        end
    endgenerate

    // out-of-range stage counts clamp to the last stage
    assign req_last = control_q[css_pkg::LAST_STAGE_LSB +: 4];
    assign wr_last = (req_last > css_pkg::LAST_STAGE_MAX)
                     ? css_pkg::LAST_STAGE_MAX : req_last;
    assign full_power = control_q[css_pkg::POWER_MODE_LSB +: 2]
                        == css_pkg::POWER_FULL;
    assign seq_end = avg_done && (stage_q == last_q);

    always_comb begin
        stage_d = stage_q;
        if (avg_done) begin
            if (stage_q == last_q) begin
                stage_d = 4'h0;
            end else begin
                stage_d = stage_q + 4'h1;
            end
        end
    end

    // a sequence stays open to new settings until its first sample
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fresh_q <= 1'b1;
        end else if (seq_end) begin
            fresh_q <= 1'b1;
        end else if (sample_en && running_q) begin
            fresh_q <= 1'b0;
        end
    end

    // settings latch only between sequences so no stage mixes them
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage_q <= 4'h0;
            decim_q <= css_pkg::DECIM_256;
            last_q <= 4'h0;
            running_q <= 1'b0;
        end else begin
            stage_q <= stage_d;
            if (seq_end || !running_q || fresh_q) begin
                decim_q <= control_q[css_pkg::DECIM_LSB +: 2];
                last_q <= wr_last;
                // in full power the next sequence starts without a gap; other power modes stop here
                running_q <= full_power;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            active_stage <= 4'h0;
            active_cfg <= '0;
        end else begin
            active_stage <= stage_d;
            active_cfg <= build_cfg(route_lo_q[stage_d], route_hi_q[stage_d],
                                    offset_q[stage_d]);
        end
    end

    // a differential pair pressed together cancels near midscale
    assign is_diff = active_cfg.se_setup == css_pkg::SE_DIFFERENTIAL;
    assign hi_side = avg_result > (css_pkg::MIDSCALE + css_pkg::BUTTON_BAND);
    assign lo_side = avg_result < (css_pkg::MIDSCALE - css_pkg::BUTTON_BAND);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            result_q <= '0;
            result_valid <= 1'b0;
            button_pos_active <= '0;
            button_neg_active <= '0;
        end else begin
            result_valid <= avg_done;
            if (avg_done) begin
                result_q[stage_q] <= avg_result;
                button_pos_active[stage_q] <= is_diff && hi_side;
                button_neg_active[stage_q] <= is_diff && lo_side;
            end
        end
    end

    sequence seq_last_done;
        avg_done && stage_q == last_q;
    endsequence

    sequence seq_mid_done;
        avg_done && stage_q != last_q;
    endsequence

    sample_rate_a: assert property (@(posedge clk) disable iff (!reset_n)
        sample_en |-> ##[400:400] sample_en)
        else $error("sample enable period is not 400 cycles");

    sample_gap_a: assert property (@(posedge clk) disable iff (!reset_n)
        sample_en |=> !sample_en [*8])
        else $error("sample enable repeated too soon");

    stage_step_a: assert property (@(posedge clk) disable iff (!reset_n)
        seq_mid_done |=> stage_q == $past(stage_q) + 4'h1)
        else $error("stage did not advance by one");

    stage_wrap_a: assert property (@(posedge clk) disable iff (!reset_n)
        seq_last_done |=> stage_q == 4'h0)
        else $error("sequence did not wrap to first stage");

    stage_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        !avg_done |=> $stable(stage_q))
        else $error("stage moved without a result");

    stage_limit_a: assert property (@(posedge clk) disable iff (!reset_n)
        last_q <= css_pkg::LAST_STAGE_MAX && stage_q <= last_q)
        else $error("stage beyond eleven");

    result_only_a: assert property (@(posedge clk) disable iff (!reset_n)
        !avg_done |=> result_q == $past(result_q))
        else $error("result register changed without completion");

    cfg_boundary_a: assert property (@(posedge clk) disable iff (!reset_n)
        running_q && !seq_end && !fresh_q
        |=> $stable(decim_q) && $stable(last_q))
        else $error("settings changed inside a sequence");

    button_excl_a: assert property (@(posedge clk) disable iff (!reset_n)
        (button_pos_active & button_neg_active) == '0)
        else $error("both buttons of a pair reported");

    no_gap_a: assert property (@(posedge clk) disable iff (!reset_n)
        seq_last_done and full_power |=> running_q)
        else $error("idle gap between sequences");
endmodule

// file: shared/css_pkg.sv
package css_pkg;

    localparam int CLK_KHZ = 100000;
    localparam int SAMPLE_RATE_KHZ = 250;
    localparam int SAMPLE_DIV = CLK_KHZ / SAMPLE_RATE_KHZ;
    localparam int SAMPLE_DIV_W = 9;

    localparam int NUM_INPUTS = 13;
    localparam int NUM_STAGES = 12;
    localparam int RESULT_W = 16;
    localparam int OFFSET_W = 6;
    localparam int ACC_W = 26;
    localparam int CNT_W = 10;
    localparam logic [3:0] LAST_STAGE_MAX = 4'hB;

    localparam logic [1:0] DECIM_256 = 2'h0;
    localparam logic [1:0] DECIM_128 = 2'h1;
    localparam int SAMPLES_PER_RATIO = 3;
    localparam logic [35:0] DIV3_MUL = 36'h0002AAAB;
    localparam int DIV3_SHIFT = 19;

    localparam logic [9:0] ADDR_CONTROL = 10'h000;
    localparam logic [9:0] ADDR_RESULT_FIRST = 10'h00B;
    localparam logic [9:0] ADDR_STAGE_BASE = 10'h080;
    localparam int STAGE_STRIDE_LOG2 = 3;
    localparam logic [2:0] SUB_ROUTE_LO = 3'h0;
    localparam logic [2:0] SUB_ROUTE_HI = 3'h1;
    localparam logic [2:0] SUB_OFFSET = 3'h2;

    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] CONTROL_MASK = 16'h03FF;
    localparam int POWER_MODE_LSB = 0;
    localparam int LAST_STAGE_LSB = 4;
    localparam int DECIM_LSB = 8;
    localparam logic [1:0] POWER_FULL = 2'h0;
    localparam int POS_OFFSET_LSB = 0;
    localparam int NEG_OFFSET_LSB = 8;
    localparam int SE_SETUP_LSB = 12;
    localparam logic [1:0] SE_DIFFERENTIAL = 2'h3;

    localparam logic [15:0] MIDSCALE = 16'h8000;
    localparam logic [15:0] BUTTON_BAND = 16'h0400;

    typedef struct packed {
        logic [1:0] se_setup;
        logic [2*NUM_INPUTS-1:0] routing;
        logic [OFFSET_W-1:0] pos_offset;
        logic [OFFSET_W-1:0] neg_offset;
    } css_stage_cfg_s;

    typedef struct packed {
        logic [9:0] addr;
        logic [15:0] wdata;
        logic we;
    } css_reg_req_s;

    function automatic logic [3:0] css_ratio_log2(input logic [1:0] code);
        case (code)
            DECIM_256: css_ratio_log2 = 4'h8;
            DECIM_128: css_ratio_log2 = 4'h7;
            default: css_ratio_log2 = 4'h6;
        endcase
    endfunction

endpackage

// file: hw/css_averager.sv
module css_averager (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic sample_en,
    input wire logic [15:0] sample,
    input wire logic [1:0] decim,
    output logic done,
    output logic [15:0] result
);
    logic [css_pkg::ACC_W-1:0] acc_q;
    logic [css_pkg::CNT_W-1:0] cnt_q;
    logic [3:0] shift;
    logic [css_pkg::CNT_W-1:0] last_cnt;
    logic [css_pkg::ACC_W-1:0] acc_sum;
    logic [35:0] per_ratio;
    logic [35:0] quotient;
    logic last_sample;

    assign shift = css_pkg::css_ratio_log2(decim);
    // three windows of the ratio per stage
    assign last_cnt = css_pkg::CNT_W'((css_pkg::SAMPLES_PER_RATIO << shift)
                                      - 1);
    assign acc_sum = acc_q + css_pkg::ACC_W'(sample);
    assign per_ratio = 36'(acc_sum >> shift);
    // exact divide by three for sums below 2^18
    assign quotient = (per_ratio * css_pkg::DIV3_MUL) >> css_pkg::DIV3_SHIFT;
    assign last_sample = sample_en && (cnt_q == last_cnt);

    // done rises in the same cycle the result register loads, so the sequencer never stores
    // the previous stage's value
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            done <= 1'b0;
        end else begin
            done <= last_sample;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_q <= '0;
            cnt_q <= '0;
            result <= '0;
        end else if (last_sample) begin
            acc_q <= '0;
            cnt_q <= '0;
            result <= quotient[15:0];
        end else if (sample_en) begin
            acc_q <= acc_sum;
            cnt_q <= cnt_q + 1'b1;
        end
    end

    count_window_a: assert property (@(posedge clk) disable iff (!reset_n)
        last_sample |=> cnt_q == '0 && acc_q == '0)
        else $error("averager did not restart after a result");
endmodule

// file: verif/css_sensor_model.sv
module css_sensor_model (
    input wire logic clk,
    input wire logic sample_strobe,
    input wire css_pkg::css_stage_cfg_s active_cfg,
    output logic [15:0] mod_sample
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tog_q;
    logic [15:0] level;
    initial tog_q = 1'b0;
    always @(posedge clk) tog_q <= ~tog_q;
    // a differential electrode pair sits well above midscale
    assign level = (active_cfg.se_setup == css_pkg::SE_DIFFERENTIAL)
        ? 16'h9000 : 16'h1234;
    // outside a sample slot the word is junk so a late sample shows up
    assign mod_sample = sample_strobe ? level :
        (tog_q ? ~level : 16'hA5A5);
endmodule

// file: verif/tb_css_stage_sequencer.sv
module tb_css_stage_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk;
    logic reset_n;
    logic [15:0] mod_sample;
    logic sample_strobe;
    css_pkg::css_reg_req_s req;
    logic [15:0] reg_rdata;
    logic [3:0] active_stage;
    css_pkg::css_stage_cfg_s active_cfg;
    logic result_valid;
    logic [css_pkg::NUM_STAGES-1:0] pos_act;
    logic [css_pkg::NUM_STAGES-1:0] neg_act;
    int fails = 0;
    int compares = 0;
    int cycle_count = 0;
    int t_release;
    int t_res;
    int t_prev;

    css_stage_sequencer dut (
        .clk(clk),
        .reset_n(reset_n),
        .mod_sample(mod_sample),
        .sample_strobe(sample_strobe),
        .reg_req(req),
        .reg_rdata(reg_rdata),
        .active_stage(active_stage),
        .active_cfg(active_cfg),
        .result_valid(result_valid),
        .button_pos_active(pos_act),
        .button_neg_active(neg_act)
    );

    css_sensor_model sensor (
        .clk(clk),
        .sample_strobe(sample_strobe),
        .active_cfg(active_cfg),
        .mod_sample(mod_sample)
    );

    initial clk = 1'b0;
    always #5 clk = ~clk;
    always @(posedge clk) cycle_count++;

    task automatic final_report();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check_val(input string name, input logic [39:0] exp,
                             input logic [39:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic reg_write(input logic [9:0] a, input logic [15:0] d);
        @(negedge clk);
        req.addr = a;
        req.wdata = d;
        req.we = 1'b1;
        @(negedge clk);
        req.we = 1'b0;
    endtask

    task automatic reg_check(input string name, input logic [9:0] a,
                             input logic [15:0] exp);
        @(negedge clk);
        req.addr = a;
        req.we = 1'b0;
        @(negedge clk);
        check_val(name, {24'h0, exp}, {24'h0, reg_rdata});
    endtask

    // waits for the next stored result and stamps its cycle
    task automatic wait_result();
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (result_valid !== 1'b1 && n < 100000);
        if (n >= 100000) begin
            fails++;
            final_report();
        end
        t_prev = t_res;
        t_res = cycle_count;
    endtask

    task automatic t_reset_values();
        check_val("active_stage", 40'h0,
            {36'h0, active_stage});
        reg_check("control", css_pkg::ADDR_CONTROL,
            16'h0000);
        reg_check("result0", css_pkg::ADDR_RESULT_FIRST,
            16'h0000);
        reg_check("unmapped", 10'h3FF, 16'h0000);
    endtask

    // all of this lands before the first sample, 400 cycles in
    task automatic t_reg_access();
        // top bits ignored; decim 64, last index 0, full power
        reg_write(css_pkg::ADDR_CONTROL, 16'hFE00);
        reg_check("control", css_pkg::ADDR_CONTROL,
            16'h0200);
        // only stage 0 is in use, so only it would be calibrated
        reg_write(10'h080, 16'h3FFE);
        reg_write(10'h081, 16'hFFFF);
        reg_write(10'h082, 16'h0101);
        reg_check("offset_step", 10'h082, 16'h0101);
        reg_write(10'h082, 16'hFFFF);
        reg_check("route_lo0", 10'h080, 16'h3FFE);
        reg_check("route_hi0", 10'h081, 16'h3FFF);
        reg_check("offset0", 10'h082, 16'h3F3F);
        reg_write(10'h00B, 16'h5555);
        reg_check("result0_ro", 10'h00B, 16'h0000);
    endtask

    task automatic t_first_seq();
        wait_result();
        // settings written before the first sample govern this sequence
        check_val("first_late", 40'h1,
            {39'h0, (t_res - t_release) >= 76800});
        check_val("first_early", 40'h1,
            {39'h0, (t_res - t_release) <= 77203});
        check_val("wrap_stage", 40'h0,
            {36'h0, active_stage});
        check_val("cfg0", {2'h3, 26'h3FFFFFE, 6'h3F, 6'h3F},
            active_cfg);
        check_val("pos_btn", 40'h1, {39'h0, pos_act[0]});
        check_val("neg_btn", 40'h0, {39'h0, neg_act[0]});
        reg_check("result0", css_pkg::ADDR_RESULT_FIRST,
            16'h9000);
    endtask

    task automatic t_second_seq();
        wait_result();
        check_val("stage_time64", 40'd76800,
            40'(t_res - t_prev));
        check_val("seq_time", 40'd76800,
            40'(t_res - t_prev));
        check_val("seq_gapless", 40'd76800,
            40'(t_res - t_prev));
        check_val("wrap_stage2", 40'h0,
            {36'h0, active_stage});
        check_val("pos_all", 40'h1, {28'h0, pos_act});
        check_val("neg_all", 40'h0, {28'h0, neg_act});
        reg_check("result0_again", css_pkg::ADDR_RESULT_FIRST,
            16'h9000);
        reg_check("result1_idle", 10'h00C, 16'h0000);
    endtask

    // two stage times at ratio 64 plus margin
    initial begin
        repeat (200000) @(posedge clk);
        fails++;
        final_report();
    end

    initial begin
        reset_n = 1'b0;
        req = '0;
        t_res = 0;
        t_prev = 0;
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        t_release = cycle_count;
        t_reset_values();
        t_reg_access();
        t_first_seq();
        t_second_seq();
        final_report();
    end
endmodule
